// File: design/sdr_device.sv
/*
 sdr_device: command-level SDRAM end: bank/row state, mode register, read and write
 bursts with latency, truncation, mask and auto-precharge.
 Assumes commands come from logic on the same pclk; ce freezes all state.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_device
	import sdr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	sdr_bus_if.dev bus,
	output logic [A_W-1:0] mode_o,
	output logic [NBANK-1:0] bank_open_o
);

	function automatic logic [3:0] burst_len(input logic [2:0] code);
		case (code)
			3'h0: burst_len = 4'h1;
			3'h1: burst_len = 4'h2;
			3'h2: burst_len = 4'h4;
			3'h3: burst_len = 4'h8;
			BL_FULL_PAGE: burst_len = 4'h0;
			default: burst_len = 4'h1;
		endcase
	endfunction : burst_len

	// length zero stands for a full page, which wraps over the whole row
	function automatic logic [COL_W-1:0] burst_col(
		input logic [COL_W-1:0] s,
		input logic [COL_W-1:0] i,
		input logic [3:0] len,
		input logic ilv
	);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] off;
		m = (len == 4'h0) ? {COL_W{1'b1}} : COL_W'(len - 4'h1);
		off = (ilv && len != 4'h0) ? (s ^ i) : COL_W'(s + i);
		burst_col = (s & ~m) | (off & m);
	endfunction : burst_col

	function automatic logic [MEM_AW-1:0] mem_idx(
		input logic [BA_W-1:0] b,
		input logic [ROW_KEEP-1:0] r,
		input logic [COL_W-1:0] c
	);
		mem_idx = {b, r, c};
	endfunction : mem_idx

	logic [A_W-1:0] mode_reg;
	logic [NBANK-1:0] open_reg;
	logic [NBANK-1:0] open_next;
	logic [ROW_KEEP-1:0] row_reg [NBANK];
	logic [DQ_W-1:0] mem [MEM_WORDS];
	logic g_act_reg;
	logic g_wr_reg;
	logic g_ap_reg;
	logic [BA_W-1:0] g_bank_reg;
	logic [COL_W-1:0] g_start_reg;
	logic [COL_W-1:0] g_idx_reg;
	logic [3:0] g_len_reg;
	logic pipe_v_reg;
	logic [DQ_W-1:0] pipe_d_reg;
	logic out_v_reg;
	logic [DQ_W-1:0] out_d_reg;
	logic [1:0] dq_oe_reg;
	logic [1:0] dqm_d1_reg;

	wire sdr_cmd_t cmd;
	wire logic [2:0] bl_code;
	wire logic [3:0] rd_len;
	wire logic [3:0] wr_len;
	wire logic cl3;
	wire logic ilv;
	wire logic is_rd;
	wire logic is_wr;
	wire logic is_bst;
	wire logic is_pre;
	wire logic act_new;
	wire logic pre_hit;
	wire logic rd_busy;
	wire logic wr_ok;
	wire logic wr_ap_now;
	wire logic [COL_W-1:0] g_col;
	wire logic g_last;
	wire logic g_adv;
	wire logic ap_done;
	wire logic stage0_v;
	wire logic [DQ_W-1:0] stage0_d;
	wire logic sel_v;
	wire logic [DQ_W-1:0] sel_d;
	wire logic wr_en;
	wire logic [MEM_AW-1:0] wr_at;
	wire logic [1:0] wr_be;

	// chip deselect reads as no operation
	assign cmd = bus.cs_n ? CMD_NOP : sdr_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});
	assign bl_code = mode_reg[MR_BL_LSB +: 3];
	assign rd_len = burst_len(bl_code);
	assign wr_len = mode_reg[MR_WBM_BIT] ? 4'h1 : rd_len;
	assign cl3 = mode_reg[MR_CL_LSB +: 3] == CL_THREE;
	assign ilv = mode_reg[MR_BT_BIT];

	assign is_rd = (cmd == CMD_RD) && open_reg[bus.ba];
	assign is_wr = cmd == CMD_WR;
	assign is_bst = cmd == CMD_BST;
	assign is_pre = cmd == CMD_PRE;
	assign act_new = (cmd == CMD_ACT) && !open_reg[bus.ba];
	assign pre_hit = is_pre && g_act_reg && (bus.addr[AP_BIT] || bus.ba == g_bank_reg);

	// a write cutting into read data is honoured only if the mask stood the clock before
	assign rd_busy = (g_act_reg && !g_wr_reg) || pipe_v_reg || out_v_reg;
	assign wr_ok = is_wr && open_reg[bus.ba] && (!rd_busy || (&dqm_d1_reg));
	assign wr_ap_now = wr_ok && wr_len == 4'h1 && bus.addr[AP_BIT];

	assign g_col = burst_col(g_start_reg, g_idx_reg, g_len_reg, ilv);
	assign g_last = (g_len_reg != 4'h0) && (g_idx_reg == COL_W'(g_len_reg - 4'h1));
	assign g_adv = g_act_reg && !is_rd && !is_wr && !is_bst && !pre_hit;
	assign ap_done = g_adv && g_last && g_ap_reg;

	assign stage0_v = g_act_reg && !g_wr_reg;
	assign stage0_d = mem[mem_idx(g_bank_reg, row_reg[g_bank_reg], g_col)];
	// latency 3 takes one more pipeline stage than latency 2
	assign sel_v = cl3 ? pipe_v_reg : stage0_v;
	assign sel_d = cl3 ? pipe_d_reg : stage0_d;

	// single write port: the command word, then the burst words
	assign wr_en = wr_ok || (g_adv && g_wr_reg);
	assign wr_at = wr_ok ? mem_idx(bus.ba, row_reg[bus.ba], bus.addr[COL_W-1:0])
		: mem_idx(g_bank_reg, row_reg[g_bank_reg], g_col);
	assign wr_be = ~bus.dqm;

	assign bus.dq_dev_out = out_d_reg;
	assign bus.dq_dev_oe = dq_oe_reg;
	assign mode_o = mode_reg;
	assign bank_open_o = open_reg;

	always_comb begin
		open_next = open_reg;
		if (ap_done) begin
			open_next[g_bank_reg] = 1'b0;
		end
		if (wr_ap_now) begin
			open_next[bus.ba] = 1'b0;
		end
		if (is_pre) begin
			if (bus.addr[AP_BIT]) begin
				open_next = '0;
			end else begin
				open_next[bus.ba] = 1'b0;
			end
		end
		if (act_new) begin
			open_next[bus.ba] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MR_RESET;
			open_reg <= '0;
		end else if (ce) begin
			if (cmd == CMD_LMR) begin
				mode_reg <= bus.addr;
			end
			open_reg <= open_next;
		end
	end

	always_ff @(posedge pclk) begin
		if (ce && act_new) begin
			row_reg[bus.ba] <= bus.addr[ROW_KEEP-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g_act_reg <= 1'b0;
			g_wr_reg <= 1'b0;
			g_ap_reg <= 1'b0;
			g_bank_reg <= '0;
			g_start_reg <= '0;
			g_idx_reg <= '0;
			g_len_reg <= 4'h0;
		end else if (ce) begin
			if (is_rd) begin
				// a new read replaces the running burst at once
				g_act_reg <= 1'b1;
				g_wr_reg <= 1'b0;
				g_ap_reg <= bus.addr[AP_BIT];
				g_bank_reg <= bus.ba;
				g_start_reg <= bus.addr[COL_W-1:0];
				g_idx_reg <= '0;
				g_len_reg <= rd_len;
			end else if (is_wr) begin
				// word 0 is written with the command, the burst goes on from word 1
				g_act_reg <= wr_ok && wr_len != 4'h1;
				g_wr_reg <= 1'b1;
				g_ap_reg <= bus.addr[AP_BIT];
				g_bank_reg <= bus.ba;
				g_start_reg <= bus.addr[COL_W-1:0];
				g_idx_reg <= 8'h01;
				g_len_reg <= wr_len;
			end else if (is_bst || pre_hit) begin
				g_act_reg <= 1'b0;
			end else if (g_adv) begin
				if (g_last) begin
					g_act_reg <= 1'b0;
				end else begin
					g_idx_reg <= g_idx_reg + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_v_reg <= 1'b0;
			pipe_d_reg <= '0;
			out_v_reg <= 1'b0;
			out_d_reg <= '0;
			dq_oe_reg <= 2'h0;
			dqm_d1_reg <= 2'h0;
		end else if (ce) begin
			dqm_d1_reg <= bus.dqm;
			if (is_wr) begin
				pipe_v_reg <= 1'b0;
				out_v_reg <= 1'b0;
				dq_oe_reg <= 2'h0;
			end else begin
				pipe_v_reg <= stage0_v;
				pipe_d_reg <= stage0_d;
				out_v_reg <= sel_v;
				out_d_reg <= sel_d;
				// mask sampled one edge earlier hides the word two edges later
				dq_oe_reg <= sel_v ? ~dqm_d1_reg : 2'h0;
			end
		end
	end

	// no reset: array content is data, not control
	always_ff @(posedge pclk) begin
		if (ce && wr_en) begin
			if (wr_be[0]) begin
				mem[wr_at][7:0] <= bus.dq[7:0];
			end
			if (wr_be[1]) begin
				mem[wr_at][15:8] <= bus.dq[15:8];
			end
		end
	end

endmodule : sdr_device
`default_nettype wire

// File: inc/sdr_pkg.sv
/*
 sdr_pkg: constants, command codes, mode-register fields, controller register map
 and timing counts shared by the SDRAM device end and the controller end.
 Assumes a single 10 MHz clock shared by both ends.
*/
package sdr_pkg;
	localparam int DQ_W = 16;
	localparam int BA_W = 2;
	localparam int A_W = 12;
	localparam int COL_W = 8;
	localparam int NBANK = 4;
	// only the low row bits are stored, so distinct rows alias in the array
	localparam int ROW_KEEP = 4;
	localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;
	localparam int MEM_WORDS = 1 << MEM_AW;

	typedef enum logic [2:0] {
		CMD_LMR = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR = 3'h4,
		CMD_RD = 3'h5,
		CMD_BST = 3'h6,
		CMD_NOP = 3'h7
	} sdr_cmd_t;

	// mode register fields
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_OPLO_BIT = 7;
	localparam int MR_OPHI_BIT = 8;
	localparam int MR_WBM_BIT = 9;
	localparam logic [11:0] MR_RESET = 12'h020;
	localparam logic [2:0] BL_FULL_PAGE = 3'h7;
	localparam logic [2:0] CL_THREE = 3'h3;
	localparam int AP_BIT = 10;

	// controller registers (byte addresses)
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CMD_BA_LSB = 4;
	localparam int WD_DQM_LSB = 16;
	localparam logic [1:0] DQM_IDLE_RESET = 2'h0;

	// timing, 10 MHz is below every latency limit
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACT_COL_NS = 20;
	localparam int ROW_CYCLE_NS = 70;
	localparam int BANK_GAP_NS = 15;
	localparam int PRECHARGE_NS = 20;
	localparam logic [1:0] MASK_LEAD = 2'h3;

	// least times round up, never below one cycle
	function automatic int ns2cyc(input int t_ns);
		int c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		ns2cyc = (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam logic [7:0] RCD_CYC = 8'(ns2cyc(ACT_COL_NS));
	localparam logic [7:0] RC_CYC = 8'(ns2cyc(ROW_CYCLE_NS));
	localparam logic [7:0] RRD_CYC = 8'(ns2cyc(BANK_GAP_NS));
	localparam logic [7:0] RP_CYC = 8'(ns2cyc(PRECHARGE_NS));
endpackage : sdr_pkg

// File: inc/sdr_bus_if.sv
/*
 sdr_bus_if: command, address, mask and data pins between controller and device.
 Assumes both ends run on the same pclk; the shared data wire is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdr_bus_if;
	import sdr_pkg::*;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BA_W-1:0] ba;
	logic [A_W-1:0] addr;
	logic [1:0] dqm;
	logic [DQ_W-1:0] dq_ctl_out;
	logic dq_ctl_oe;
	logic [DQ_W-1:0] dq_dev_out;
	logic [1:0] dq_dev_oe;
	wire [DQ_W-1:0] dq;

	// an undriven byte reads as zero, as behind a pull-down
	assign dq[7:0] = dq_dev_oe[0] ? dq_dev_out[7:0] : (dq_ctl_oe ? dq_ctl_out[7:0] : 8'h00);
	assign dq[15:8] = dq_dev_oe[1] ? dq_dev_out[15:8] : (dq_ctl_oe ? dq_ctl_out[15:8] : 8'h00);

	modport dev(input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output dq_dev_out, dq_dev_oe);
	modport ctl(output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_out, dq_ctl_oe,
		input dq, dq_dev_oe);
endinterface : sdr_bus_if
`default_nettype wire

// File: design/sdr_ctrl.sv
/*
 sdr_ctrl: controller end; software writes commands over APB, the controller checks
 bank state and spacing, masks ahead of writes and captures read data.
 Assumes the device on the same pclk; pready answers after one setup cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_ctrl
	import sdr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sdr_bus_if.ctl bus
);

	typedef enum logic [1:0] {
		CS_IDLE = 2'b00,
		CS_WAIT = 2'b01,
		CS_MASK = 2'b10
	} sdr_cst_t;

	sdr_cst_t st_reg;
	logic [2:0] pend_reg;
	logic [BA_W-1:0] pba_reg;
	logic [A_W-1:0] addr_reg;
	logic [DQ_W-1:0] wdata_reg;
	logic [1:0] dqmu_reg;
	logic [1:0] mcnt_reg;
	logic err_reg;
	logic [NBANK-1:0] open_reg;
	logic [7:0] act_cnt_reg [NBANK];
	logic [7:0] pre_cnt_reg [NBANK];
	logic [7:0] any_act_reg;
	logic [DQ_W-1:0] rdata_reg;
	logic [7:0] rcnt_reg;
	logic [2:0] pin_reg;
	logic cs_n_reg;
	logic [BA_W-1:0] ba_pin_reg;
	logic [A_W-1:0] a_pin_reg;
	logic [1:0] dqm_reg;
	logic drv_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	wire sdr_cmd_t pcmd;
	wire logic apb_wr;
	wire logic apb_setup;
	wire logic mapped;
	wire logic [31:0] rd_mux;
	wire logic legal;
	wire logic timed;
	wire logic issue;
	wire logic mask_ph;
	wire logic [A_W-1:0] a_out;

	assign pcmd = sdr_cmd_t'(pend_reg);
	assign apb_wr = psel && penable && pready_reg && pwrite;
	assign apb_setup = psel && !penable;
	assign mapped = paddr == REG_CMD || paddr == REG_ADDR || paddr == REG_WDATA
		|| paddr == REG_STATUS || paddr == REG_RDATA;
	assign rd_mux = (paddr == REG_CMD) ? {26'h0, pba_reg, 1'b0, pend_reg}
		: (paddr == REG_ADDR) ? {20'h0, addr_reg}
		: (paddr == REG_WDATA) ? {14'h0, dqmu_reg, wdata_reg}
		: (paddr == REG_STATUS) ? {16'h0, rcnt_reg, open_reg, 2'h0, err_reg, st_reg != CS_IDLE}
		: (paddr == REG_RDATA) ? {16'h0, rdata_reg} : 32'h0;

	// only bank open/idle state makes a command legal; LMR needs every bank idle
	assign legal = (pcmd == CMD_ACT) ? !open_reg[pba_reg]
		: (pcmd == CMD_RD || pcmd == CMD_WR) ? open_reg[pba_reg]
		: (pcmd == CMD_LMR) ? (open_reg == '0) : 1'b1;
	// spacing in edges between command issues
	assign timed = (pcmd == CMD_ACT) ? (act_cnt_reg[pba_reg] >= RC_CYC
			&& pre_cnt_reg[pba_reg] >= RP_CYC && any_act_reg >= RRD_CYC)
		: (pcmd == CMD_RD || pcmd == CMD_WR) ? act_cnt_reg[pba_reg] >= RCD_CYC : 1'b1;
	assign issue = st_reg == CS_WAIT && legal && timed;
	assign mask_ph = st_reg == CS_MASK || (st_reg == CS_WAIT && pcmd == CMD_WR && !issue);
	// operating mode is always normal
	assign a_out = (pcmd == CMD_LMR) ? (addr_reg & ~(12'h001 << MR_OPLO_BIT)
		& ~(12'h001 << MR_OPHI_BIT)) : addr_reg;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign bus.cs_n = cs_n_reg;
	assign bus.ras_n = pin_reg[2];
	assign bus.cas_n = pin_reg[1];
	assign bus.we_n = pin_reg[0];
	assign bus.ba = ba_pin_reg;
	assign bus.addr = a_pin_reg;
	assign bus.dqm = dqm_reg;
	assign bus.dq_ctl_out = wdata_reg;
	assign bus.dq_ctl_oe = drv_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			addr_reg <= '0;
			wdata_reg <= '0;
			dqmu_reg <= DQM_IDLE_RESET;
			rdata_reg <= '0;
			rcnt_reg <= 8'h0;
		end else if (ce) begin
			pready_reg <= apb_setup;
			pslverr_reg <= apb_setup && !mapped;
			if (apb_setup) begin
				prdata_reg <= rd_mux;
			end
			if (apb_wr && paddr == REG_ADDR) begin
				addr_reg <= pwdata[A_W-1:0];
			end
			if (apb_wr && paddr == REG_WDATA) begin
				wdata_reg <= pwdata[DQ_W-1:0];
				dqmu_reg <= pwdata[WD_DQM_LSB +: 2];
			end
			if (|bus.dq_dev_oe) begin
				rdata_reg <= bus.dq;
				rcnt_reg <= rcnt_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= CS_IDLE;
			pend_reg <= CMD_NOP;
			pba_reg <= '0;
			mcnt_reg <= 2'h0;
			err_reg <= 1'b0;
		end else if (ce) begin
			case (st_reg)
				CS_IDLE: begin
					if (apb_wr && paddr == REG_CMD) begin
						pend_reg <= pwdata[2:0];
						pba_reg <= pwdata[CMD_BA_LSB +: BA_W];
						err_reg <= 1'b0;
						mcnt_reg <= MASK_LEAD - 2'h1;
						st_reg <= (pwdata[2:0] == CMD_WR) ? CS_MASK : CS_WAIT;
					end
				end
				CS_MASK: begin
					// mask three edges ahead so read drivers are off at the write
					if (mcnt_reg == 2'h0) begin
						st_reg <= CS_WAIT;
					end else begin
						mcnt_reg <= mcnt_reg - 2'h1;
					end
				end
				CS_WAIT: begin
					if (!legal) begin
						err_reg <= 1'b1;
						st_reg <= CS_IDLE;
					end else if (timed) begin
						st_reg <= CS_IDLE;
					end
				end
				default: st_reg <= CS_IDLE;
			endcase
			if (apb_wr && paddr == REG_CMD && st_reg != CS_IDLE) begin
				err_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_reg <= CMD_NOP;
			cs_n_reg <= 1'b1;
			ba_pin_reg <= '0;
			a_pin_reg <= '0;
			dqm_reg <= 2'h0;
			drv_reg <= 1'b0;
			open_reg <= '0;
			any_act_reg <= 8'hFF;
			for (int b = 0; b < NBANK; b++) begin
				act_cnt_reg[b] <= 8'hFF;
				pre_cnt_reg[b] <= 8'hFF;
			end
		end else if (ce) begin
			cs_n_reg <= !issue;
			pin_reg <= issue ? pend_reg : CMD_NOP;
			ba_pin_reg <= pba_reg;
			a_pin_reg <= a_out;
			// mask low at the write edge so the word is taken
			dqm_reg <= mask_ph ? 2'h3 : ((issue && pcmd == CMD_WR) ? 2'h0 : dqmu_reg);
			if (issue) begin
				drv_reg <= pcmd == CMD_WR;
			end
			if (any_act_reg != 8'hFF) begin
				any_act_reg <= any_act_reg + 8'h01;
			end
			for (int b = 0; b < NBANK; b++) begin
				if (act_cnt_reg[b] != 8'hFF) begin
					act_cnt_reg[b] <= act_cnt_reg[b] + 8'h01;
				end
				if (pre_cnt_reg[b] != 8'hFF) begin
					pre_cnt_reg[b] <= pre_cnt_reg[b] + 8'h01;
				end
				if (issue && pcmd == CMD_PRE && (a_out[AP_BIT] || pba_reg == BA_W'(b))) begin
					open_reg[b] <= 1'b0;
					pre_cnt_reg[b] <= 8'h01;
				end
			end
			// auto-precharge closes the bank behind the burst; a quick ACT may still race it
			if (issue && (pcmd == CMD_RD || pcmd == CMD_WR) && a_out[AP_BIT]) begin
				open_reg[pba_reg] <= 1'b0;
			end
			if (issue && pcmd == CMD_ACT) begin
				open_reg[pba_reg] <= 1'b1;
				act_cnt_reg[pba_reg] <= 8'h01;
				any_act_reg <= 8'h01;
			end
		end
	end

endmodule : sdr_ctrl
`default_nettype wire

// File: sim/sdr_properties.sv
/*
 sdr_properties: pin-level checks on the link between controller and device.
 Assumes one shared pclk, ce held high, and only the controller issuing commands.
*/
`timescale 1ns/1ps
`default_nettype none
module sdr_properties
	import sdr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [A_W-1:0] addr,
	input wire logic [1:0] dqm,
	input wire logic dq_ctl_oe,
	input wire logic [1:0] dq_dev_oe
);
	logic [A_W-1:0] mode_reg;
	wire [2:0] code = {ras_n, cas_n, we_n};
	wire rd = !cs_n && code == CMD_RD;
	wire wr = !cs_n && code == CMD_WR;
	wire lmr = !cs_n && code == CMD_LMR;
	wire stp = !cs_n && (code == CMD_BST || code == CMD_PRE);
	wire cl2 = mode_reg[6:4] == 3'h2;
	wire bl4 = mode_reg[2:0] == 3'h2;
	// local mirror of the mode register so latency checks follow reprogramming
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MR_RESET;
		end else if (lmr) begin
			mode_reg <= addr;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// quiet window: nothing may cut the burst short
	sequence s_rd4;
		rd && cl2 && bl4 && dqm == 2'h0 ##1 (cs_n && dqm == 2'h0) [*5];
	endsequence
	sequence s_rd3;
		rd && !cl2 && dq_dev_oe == 2'h0 ##1 dqm == 2'h0;
	endsequence
	AST_RD_LAT2: assert property (rd && cl2 && dqm == 2'h0 && dq_dev_oe == 2'h0 |-> ##1 dq_dev_oe == 2'h0 ##1 dq_dev_oe == 2'h3)
		else $error("read data not driven at latency two");
	AST_RD_LAT3: assert property (s_rd3 |-> ##1 dq_dev_oe == 2'h0 ##1 dq_dev_oe == 2'h3)
		else $error("read data not driven at latency three");
	AST_BURST_END: assert property (s_rd4 |=> dq_dev_oe == 2'h0 && $past(dq_dev_oe, 4) == 2'h3)
		else $error("fixed burst length or release wrong");
	AST_MASK_OUT: assert property (dqm != 2'h0 |-> ##2 (dq_dev_oe & $past(dqm, 2)) == 2'h0)
		else $error("masked byte still driven two clocks later");
	AST_WR_FLOAT: assert property (wr |=> dq_dev_oe == 2'h0)
		else $error("device drives data after write");
	AST_WR_LEAD: assert property (wr |-> $past(dqm, 1) == 2'h3 && $past(dqm, 2) == 2'h3 && $past(dqm, 3) == 2'h3)
		else $error("mask not raised three clocks before write");
	AST_WR_UNMASK: assert property (wr |-> dqm == 2'h0 ##1 dq_ctl_oe)
		else $error("write data masked or not driven");
	AST_NO_CONTEND: assert property (!(dq_ctl_oe && dq_dev_oe != 2'h0))
		else $error("both ends drive the data bus");
	AST_STOP: assert property (stp && cl2 |-> ##2 dq_dev_oe == 2'h0)
		else $error("read burst not stopped");
	AST_OPMODE: assert property (lmr |-> addr[8:7] == 2'h0)
		else $error("operating mode bits not zero");
endmodule : sdr_properties
`default_nettype wire

// File: sim/testbench.sv
/*
 testbench: software side over APB drives the controller, which faces the device.
 Assumes the design package and interface are compiled first; ce is held high.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sdr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr, k;
	logic [31:0] pwdata, prdata, q, d;
	logic [A_W-1:0] mode_w;
	logic [NBANK-1:0] open_w;
	int miscompares = 0;
	int num_checks = 0;
	sdr_bus_if bus_if();
	sdr_ctrl sdr_ctrl_inst(.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
	sdr_device sdr_device_inst(.pclk(pclk), .presetn(presetn), .ce(1'b1), .bus(bus_if),
		.mode_o(mode_w), .bank_open_o(open_w));
	sdr_properties sdr_properties_inst(.pclk(pclk), .presetn(presetn), .cs_n(bus_if.cs_n),
		.ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .addr(bus_if.addr),
		.dqm(bus_if.dqm), .dq_ctl_oe(bus_if.dq_ctl_oe), .dq_dev_oe(bus_if.dq_dev_oe));
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		num_checks++;
		if (x !== y) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, x, y);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count is assumed; only the watchdog ends a wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// polls busy so the next order is never dropped as a write while busy
	task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
		apb(1'b1, REG_ADDR, {20'h0, a});
		apb(1'b1, REG_CMD, {26'h0, b, 1'b0, c});
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
		end while (q[0] !== 1'b0);
	endtask : cmd
	task automatic rdw(input logic [1:0] b, input logic [11:0] a);
		logic [7:0] s;
		apb(1'b0, REG_STATUS, 32'h0);
		s = q[15:8];
		cmd(CMD_RD, b, a);
		repeat (8) @(posedge pclk);
		apb(1'b0, REG_STATUS, 32'h0);
		k = q[15:8] - s;
		apb(1'b0, REG_RDATA, 32'h0);
		d = q;
	endtask : rdw
	task automatic t_reset();
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h0, {24'h0, q[7:0]});
		chk("mode", 32'(MR_RESET), 32'(mode_w));
		chk("open", 32'h0, 32'(open_w));
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, q);
	endtask : t_reset
	task automatic t_single();
		cmd(CMD_LMR, 2'h0, 12'h3A2);
		chk("mode", 32'h222, 32'(mode_w));
		cmd(CMD_ACT, 2'h1, 12'h005);
		chk("open", 32'h2, 32'(open_w));
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, REG_WDATA, 32'h1100 + i);
			cmd(CMD_WR, 2'h1, 12'(4 + i));
		end
		rdw(2'h1, 12'h006);
		chk("last word", 32'h1101, d);
		chk("words", 32'h4, 32'(k));
		rdw(2'h1, 12'h404);
		chk("last word", 32'h1103, d);
		chk("open after ap", 32'h0, 32'(open_w));
	endtask : t_single
	task automatic t_refuse();
		cmd(CMD_RD, 2'h1, 12'h004);
		chk("err closed", 32'h1, 32'(q[1]));
		cmd(CMD_ACT, 2'h1, 12'h005);
		cmd(CMD_ACT, 2'h2, 12'h005);
		chk("open", 32'h6, 32'(open_w));
		cmd(CMD_ACT, 2'h1, 12'h009);
		chk("err act open", 32'h1, 32'(q[1]));
		cmd(CMD_LMR, 2'h0, 12'h032);
		chk("mode kept", 32'h222, 32'(mode_w));
		cmd(CMD_PRE, 2'h0, 12'h400);
		chk("open", 32'h0, 32'(open_w));
	endtask : t_refuse
	task automatic t_cl3();
		cmd(CMD_LMR, 2'h0, 12'h032);
		chk("mode", 32'h032, 32'(mode_w));
		cmd(CMD_ACT, 2'h2, 12'h003);
		apb(1'b1, REG_WDATA, 32'h0000BEEF);
		cmd(CMD_WR, 2'h2, 12'h000);
		rdw(2'h2, 12'h002);
		chk("cl3 data", 32'h0000BEEF, d);
		chk("cl3 words", 32'h4, 32'(k));
		cmd(CMD_PRE, 2'h2, 12'h000);
	endtask : t_cl3
	task automatic t_page();
		cmd(CMD_LMR, 2'h0, 12'h027);
		cmd(CMD_ACT, 2'h3, 12'h001);
		for (int i = 0; i < 2; i++) begin
			cmd(CMD_RD, 2'h3, 12'h000);
			cmd(i == 0 ? CMD_BST : CMD_PRE, 2'h3, 12'h000);
			// words already in the latency pipe still come out after the stop
			repeat (4) @(posedge pclk);
			apb(1'b0, REG_STATUS, 32'h0);
			k = q[15:8];
			repeat (20) @(posedge pclk);
			apb(1'b0, REG_STATUS, 32'h0);
			chk("page stopped", 32'(k), 32'(q[15:8]));
			chk("open", i == 0 ? 32'h8 : 32'h0, 32'(open_w));
		end
	endtask : t_page
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk; // 10 MHz, inside every latency limit
	end
	initial begin
		#3000000;
		miscompares++;
		conclude();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_single();
		t_refuse();
		t_cl3();
		t_page();
		conclude();
	end
endmodule : testbench
`default_nettype wire
